//--- dv/can_bus_node.sv
// Remote bus node: wired-AND bus with commanded dominant pulses
`timescale 1ns/1ps
module can_bus_node (
   input wire logic       clk,
   input wire logic       busTxPin,
   input wire logic       start,
   input wire logic [7:0] domLen,
   output logic           busRxPin
);
   logic [7:0] left_ff = 8'h00;
   always @(posedge clk) begin
      if (start) left_ff <= domLen;
      else if (left_ff != 8'h00) left_ff <= left_ff - 8'h01;
   end
   // Dominant from any node wins; idle bus floats recessive
   assign busRxPin = busTxPin & (left_ff == 8'h00);
endmodule : can_bus_node

//--- dv/can_mode_control_assertions.sv
// Port-level checks for CAN mode control
`timescale 1ns/1ps
module can_mode_control_assertions #(
   parameter int WAKE_CYC = 4
) (
   input wire logic                   clk,
   input wire logic                   rstn,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [7:0]             paddr,
   input wire logic [31:0]            pwdata,
   input wire logic                   pready,
   input wire logic                   busRxPin,
   input wire logic                   busTxPin,
   input wire can_mode_pkg::core_type core,
   input wire logic                   cpuStop,
   input wire logic                   coreRx,
   input wire logic                   coreAbort,
   input wire logic                   synced,
   input wire logic                   loopMode,
   input wire logic                   listenMode,
   input wire logic                   ackEnable,
   input wire logic                   errCountFreeze
);
   logic [7:0] runCnt_ff;
   // Recessive run since abort; saturates, only the threshold matters
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) runCnt_ff <= 8'h00;
      else if (coreAbort || (core.bitTick && !busRxPin)) runCnt_ff <= 8'h00;
      else if (core.bitTick && runCnt_ff < 8'h0B) runCnt_ff <= runCnt_ff + 8'h01;
   end
   // Only a return from init must resync; sleep exit need not
   logic afterInit_ff;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) afterInit_ff <= 1'b0;
      else afterInit_ff <= coreAbort || (afterInit_ff && !synced);
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence initWrite;
      psel && penable && pready && pwrite && pwdata[0]
         && paddr == can_mode_pkg::ADDR_CTL0;
   endsequence
   sequence setupPhase;
      psel && !penable;
   endsequence
   apb_answer_a: assert property (setupPhase |=> pready ##1 !pready)
      else $error("pready not a single cycle after setup");
   init_tx_recessive_a: assert property (initWrite |-> ##2 busTxPin && coreAbort)
      else $error("init request left tx pin driven");
   stop_tx_a: assert property (cpuStop |=> busTxPin)
      else $error("tx pin not recessive in stop");
   loop_tx_a: assert property (loopMode |-> busTxPin)
      else $error("tx pin not recessive in loopback");
   loop_rx_a: assert property (loopMode && $past(loopMode) |-> coreRx == $past(core.coreTx))
      else $error("loopback stream not routed to receiver");
   pin_rx_a: assert property (!loopMode && !$past(loopMode) |-> coreRx == $past(busRxPin))
      else $error("receiver not fed from pin");
   listen_quiet_a: assert property (listenMode |-> !ackEnable && errCountFreeze)
      else $error("listen only mode still acknowledges");
   resync_run_a: assert property ($rose(synced) && !core.busOff && afterInit_ff
      |-> runCnt_ff >= 8'h0A)
      else $error("synchronized before recessive run");
endmodule : can_mode_control_assertions

bind can_mode_control can_mode_control_assertions #(.WAKE_CYC(WAKE_CYC)) chk (
   .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .busRxPin, .busTxPin, .core, .cpuStop, .coreRx, .coreAbort, .synced,
   .loopMode, .listenMode, .ackEnable, .errCountFreeze);

//--- dv/test_can_mode_control.sv
// Directed APB bench for CAN mode control
`timescale 1ns/1ps
module test_can_mode_control;
   localparam logic [7:0] A0 = can_mode_pkg::ADDR_CTL0;
   localparam logic [7:0] A1 = can_mode_pkg::ADDR_CTL1;
   logic clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, specialMode = 1'h0, cpuStop = 1'h0;
   logic cpuWait = 1'h0, go = 1'h0, txOn = 1'h0;
   logic [7:0] paddr = 8'h00, pulseLen = 8'h00, q;
   logic [7:0] rxStateIn = 8'h14, txStateIn = 8'h08;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, busRxPin, busTxPin, coreRx, coreAbort, synced;
   logic useBusClock, moduleOn, loopMode, listenMode, ackEnable;
   logic errorFrameEnable, errCountFreeze, wakeEvent;
   can_mode_pkg::core_type core = '0;
   int errors = 0, checksDone = 0, cyc = 0, wakes = 0;

   can_mode_control #(.WAKE_CYC(4)) dut (.*);
   can_bus_node node (.clk, .busTxPin, .start(go), .domLen(pulseLen), .busRxPin);

   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      core.bitTick <= (cyc % 4 == 3);
      core.coreTx <= !txOn || cyc[2];
      if (wakeEvent === 1'h1) wakes <= wakes + 1;
      if (cyc == 20000) begin
         errors = errors + 1;
         end_of_test();
      end
   end
   ////////////////////////////////////////
   task automatic end_of_test;
      if (errors == 0 && checksDone > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [7:0] g, e);
      checksDone = checksDone + 1;
      if (g !== e) begin
         errors = errors + 1;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // Data taken at the rising edge that sees pready; idle edge after
   task automatic xfer(input logic w, input logic [7:0] a, d);
      psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk) penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      q = prdata[7:0];
      {psel, penable} <= 2'h0;
      @(posedge clk);
   endtask : xfer
   task automatic wr(input logic [7:0] a, d);
      xfer(1'h1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, m, e, input int n);
      repeat (n) begin
         xfer(1'h0, a, 8'h00);
         if ((q & m) === e) break;
      end
      chk(q & m, e);
   endtask : rd
   task automatic sync_wait;
      repeat (400) if (synced !== 1'h1) @(posedge clk);
      chk({7'h00, synced}, 8'h01);
   endtask : sync_wait
   task automatic pulse(input logic [7:0] n);
      go <= 1'h1; pulseLen <= n;
      @(posedge clk) go <= 1'h0;
      repeat (16) @(posedge clk);
   endtask : pulse
   ////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'h1;
      sync_wait();
      wr(can_mode_pkg::ADDR_BTRA, 8'h5A); wr(A1, 8'h80);
      rd(can_mode_pkg::ADDR_BTRA, 8'hFF, 8'h00, 1);
      rd(A1, 8'hFF, 8'h00, 1);
      wr(can_mode_pkg::ADDR_TXIE, 8'h07);
      wr(can_mode_pkg::ADDR_RXIE, 8'h03);
      wr(A0, 8'h02); rd(A1, 8'h02, 8'h02, 20);
      wr(A0, 8'h01); rd(A1, 8'h01, 8'h01, 20);
      rd(A0, 8'h07, 8'h01, 1);
      rd(can_mode_pkg::ADDR_TXIE, 8'hFF, 8'h08, 1);
      rd(can_mode_pkg::ADDR_RXIE, 8'hFF, 8'h14, 1);
      txOn <= 1'h1; wr(A1, 8'hF0); rd(A1, 8'hF0, 8'hF0, 1);
      chk({moduleOn, useBusClock, loopMode, listenMode, ackEnable,
           errCountFreeze, !errorFrameEnable, pslverr},
          8'hF6);
      wr(can_mode_pkg::ADDR_BTRA, 8'h5A);
      rd(can_mode_pkg::ADDR_BTRA, 8'hFF, 8'h5A, 1);
      wr(A1, 8'h04); rd(A1, 8'hF4, 8'h84, 1);
      specialMode <= 1'h1; wr(A1, 8'h04); rd(A1, 8'hF4, 8'h04, 1);
      wr(A1, 8'h84); specialMode <= 1'h0; txOn <= 1'h0;
      wr(A0, 8'h04); rd(A1, 8'h01, 8'h00, 20);
      sync_wait();
      core.rxBusy <= 1'h1; wr(A0, 8'h06); rd(A1, 8'h02, 8'h00, 1);
      wr(A0, 8'h04); rd(A0, 8'h02, 8'h02, 1);
      core.rxBusy <= 1'h0; rd(A1, 8'h02, 8'h02, 20);
      pulse(8'h02); rd(A1, 8'h02, 8'h02, 1);
      pulse(8'h08); rd(A1, 8'h02, 8'h00, 20);
      rd(A0, 8'h02, 8'h00, 1);
      wr(A0, 8'h02); rd(A1, 8'h02, 8'h02, 20);
      pulse(8'h08); rd(A1, 8'h02, 8'h02, 1);
      wr(A0, 8'h00); rd(A1, 8'h02, 8'h00, 20);
      txOn <= 1'h1; cpuStop <= 1'h1;
      repeat (8) @(posedge clk);
      cpuStop <= 1'h0;
      wr(A0, 8'h20); cpuWait <= 1'h1; @(posedge clk);
      repeat (8) @(negedge clk) chk({7'h00, busTxPin}, 8'h01);
      chk(8'(wakes), 8'h01);
      end_of_test();
   end
endmodule : test_can_mode_control

//--- shared/can_mode_pkg.sv
// Register map, field layout and timing constants for CAN mode control
package can_mode_pkg;
   // Byte addresses of the register words
   localparam logic [7:0] ADDR_CTL0    = 8'h00;
   localparam logic [7:0] ADDR_CTL1    = 8'h04;
   localparam logic [7:0] ADDR_RXFLAG  = 8'h08;
   localparam logic [7:0] ADDR_RXIE    = 8'h0C;
   localparam logic [7:0] ADDR_TXFLAG  = 8'h10;
   localparam logic [7:0] ADDR_TXIE    = 8'h14;
   localparam logic [7:0] ADDR_TXABRQ  = 8'h18;
   localparam logic [7:0] ADDR_TXABAK  = 8'h1C;
   localparam logic [7:0] ADDR_TXBSEL  = 8'h20;
   localparam logic [7:0] ADDR_BTRA    = 8'h24;
   localparam logic [7:0] ADDR_BTRB    = 8'h28;
   localparam logic [7:0] ADDR_ACCCTL  = 8'h2C;
   localparam logic [7:0] ADDR_CODE0   = 8'h30;
   localparam logic [7:0] ADDR_MASK0   = 8'h50;
   localparam logic [7:0] ADDR_STATUS  = 8'h70;
   localparam int         ACC_REGS     = 8;
   localparam int         ACC_IDX_LSB  = 2;
   localparam int         ACC_IDX_W    = 3;
   localparam logic [7:0] ACC_SPAN     = 8'h20;

   // Primary control fields
   localparam int CTL0_INIT_REQUEST  = 0;
   localparam int CTL0_SLEEP_REQUEST   = 1;
   localparam int CTL0_WAKEEN  = 2;
   localparam int CTL0_CSWAIT  = 5;
   // Secondary control fields
   localparam int CTL1_INIT_ACK  = 0;
   localparam int CTL1_SLEEP_ACK   = 1;
   localparam int CTL1_WAKEFLT = 2;
   localparam int CTL1_LISTEN  = 4;
   localparam int CTL1_LOOP    = 5;
   localparam int CTL1_CLKSEL  = 6;
   localparam int CTL1_ENABLE  = 7;
   // Masks of rx/tx state fields kept across init
   localparam logic [7:0] KEEP_RX_STATE = 8'h3C;
   localparam logic [7:0] KEEP_TX_STATE = 8'h0C;
   // Bits of primary control kept across init
   localparam logic [7:0] KEEP_CTL0 = 8'h07;

   localparam logic [7:0] RST_CTL0   = 8'h00;
   localparam logic [7:0] RST_CTL1   = 8'h01;
   localparam logic [7:0] RST_RXFLAG = 8'h00;
   localparam logic [7:0] RST_RXIE   = 8'h00;
   localparam logic [7:0] RST_TXFLAG = 8'h07;
   localparam logic [7:0] RST_TXIE   = 8'h00;
   localparam logic [7:0] RST_TXABRQ = 8'h00;
   localparam logic [7:0] RST_TXABAK = 8'h00;
   localparam logic [7:0] RST_TXBSEL = 8'h00;
   localparam logic [7:0] RST_BTR    = 8'h00;
   localparam logic [7:0] RST_ACC    = 8'h00;
   localparam logic [7:0] TX_EMPTY   = 8'h07;

   // Resync: recessive bits per idle run and runs to leave bus-off
   localparam int IDLE_BITS    = 11;
   localparam int BUSOFF_RUNS  = 128;
   // Wake filter dominant length
   localparam int WAKE_PULSE_NS = 2000;
   localparam int CLK_MHZ       = 50;
   localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [2:0] {
      RUN, SLEEP, INIT, RESYNC
   } mode_type;

   // Events from the protocol core
   typedef struct packed {
      logic rxBusy;
      logic busOff;
      logic bitTick;
      logic coreTx;
   } core_type;
endpackage : can_mode_pkg

//--- src/can_mode_control.sv
// APB mode, handshake and bus pin control for a CAN controller
`timescale 1ns/1ps

// Behaviour
// (RULE1) Wake enable lets bus traffic end sleep
// (RULE2) Sleep entered only when bus idle
// (RULE3) Sleep acknowledged; persists until clear or wake
// (RULE4) Sleep request clear ignored before sleep entered
// (RULE5) Init request aborts frames, drops sync, acknowledges
// (RULE6) Init resets control and flag registers
// (RULE7) Init keeps wake, requests and state fields
// (RULE8) Config registers writable only during init
// (RULE9) Error counters untouched by init
// (RULE10) Resync after 11 recessive, bus-off 128 runs
// (RULE11) Software writes other bits only after init
// (RULE12) Init request clear ignored before init entered
// (RULE13) Tx pin recessive at once on init request
// (RULE14) Software should sleep before requesting init
// (RULE15) Tx recessive in stop or clock-stopped wait
// (RULE16) Enable bit write-once normal, free special mode
// (RULE17) Clock select picks oscillator or bus clock
// (RULE18) Loopback routes tx to rx, pin recessive
// (RULE19) Loopback ignores ack slot, raises both events
// (RULE20) Listen only: no ack, errors, transmit; frozen
// (RULE21) Wake filter: any edge or filtered pulse; unfiltered, code wakes on the recessive-to-dominant edge only
// (RULE22) Bus activity in sleep clears sleep ack
// (RULE23) Ack clears once mode actually left
module can_mode_control #(
   parameter int WAKE_CYC = can_mode_pkg::WAKE_PULSE_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 rstn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   input  wire logic                 busRxPin,
   output logic                      busTxPin,
   input  wire can_mode_pkg::core_type core,
   input  wire logic [7:0]           rxStateIn,
   input  wire logic [7:0]           txStateIn,
   input  wire logic                 specialMode,
   input  wire logic                 cpuStop,
   input  wire logic                 cpuWait,
   output logic                      coreRx,
   output logic                      coreAbort,
   output logic                      synced,
   output logic                      useBusClock,
   output logic                      moduleOn,
   output logic                      loopMode,
   output logic                      listenMode,
   output logic                      ackEnable,
   output logic                      errorFrameEnable,
   output logic                      errCountFreeze,
   output logic                      wakeEvent
);
   ///////////////////////////////////////////////////////////////////////
   can_mode_pkg::mode_type mode_ff;
   logic [7:0] ctl0_ff, ctl1_ff, rxFlag_ff, rxIe_ff, txFlag_ff, txIe_ff;
   logic [7:0] txAbRq_ff, txAbAk_ff, txBsel_ff, btrA_ff, btrB_ff;
   logic [7:0] accCtl_ff;
   logic [7:0] code_ff [can_mode_pkg::ACC_REGS];
   logic [7:0] mask_ff [can_mode_pkg::ACC_REGS];
   logic       enWritten_ff, rxPrev_ff, wakeEvent_ff;
   logic [3:0] recCnt_ff;
   logic [7:0] runCnt_ff;
   logic [15:0] domCnt_ff;
   logic       busOffAtStart_ff;

   logic wr, rd, init_request, sleep_request, init_ack, sleep_ack, inInit, inSleep;
   logic wakeEn, busIdle, rxBit, activity, cfgOpen, resyncDone;
   logic [7:0] wd, nxt_ctl0;

   assign wr      = psel && penable && pwrite;
   assign rd      = psel && penable && !pwrite;
   assign wd      = pwdata[7:0];
   assign init_request  = ctl0_ff[can_mode_pkg::CTL0_INIT_REQUEST];
   assign sleep_request   = ctl0_ff[can_mode_pkg::CTL0_SLEEP_REQUEST];
   assign wakeEn  = ctl0_ff[can_mode_pkg::CTL0_WAKEEN];
   assign init_ack  = ctl1_ff[can_mode_pkg::CTL1_INIT_ACK];
   assign sleep_ack   = ctl1_ff[can_mode_pkg::CTL1_SLEEP_ACK];
   assign inInit  = init_request && init_ack;
   assign inSleep = sleep_request && sleep_ack;
   assign cfgOpen = inInit; // RULE8
   // Rx side in loopback is the own tx stream, not the pin
   assign rxBit   = ctl1_ff[can_mode_pkg::CTL1_LOOP] ? core.coreTx
                                                     : busRxPin; // RULE18
   assign busIdle = !core.rxBusy && (txFlag_ff == can_mode_pkg::TX_EMPTY); // RULE2
   ///////////////////////////////////////////////////////////////////////
   // Wake detection: edge, or dominant run of the filter length
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rxPrev_ff <= 1'b1;
         domCnt_ff <= 16'h0000;
      end else begin
         rxPrev_ff <= busRxPin;
         if (busRxPin) begin
            domCnt_ff <= 16'h0000;
         end else if (domCnt_ff != 16'hFFFF) begin
            domCnt_ff <= domCnt_ff + 16'h0001;
         end
      end
   end

   always_comb begin
      if (ctl1_ff[can_mode_pkg::CTL1_WAKEFLT]) begin
         activity = (domCnt_ff == 16'(WAKE_CYC - 1)) && !busRxPin; // RULE21
      end else begin
         activity = rxPrev_ff && !busRxPin; // RULE21
      end
   end
   ///////////////////////////////////////////////////////////////////////
   // Resync counter: runs of recessive bits at bit ticks
   assign resyncDone = busOffAtStart_ff
      ? (runCnt_ff == 8'(can_mode_pkg::BUSOFF_RUNS))
      : (runCnt_ff != 8'h00); // RULE10

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         recCnt_ff <= 4'h0;
         runCnt_ff <= 8'h00;
      end else if (mode_ff != can_mode_pkg::RESYNC) begin
         recCnt_ff <= 4'h0;
         runCnt_ff <= 8'h00;
      end else if (core.bitTick && !resyncDone) begin
         if (!rxBit) begin
            recCnt_ff <= 4'h0;
         end else if (recCnt_ff == 4'(can_mode_pkg::IDLE_BITS - 1)) begin
            recCnt_ff <= 4'h0;
            runCnt_ff <= runCnt_ff + 8'h01; // RULE10
         end else begin
            recCnt_ff <= recCnt_ff + 4'h1;
         end
      end
   end
   ///////////////////////////////////////////////////////////////////////
   // Mode machine and handshake flags
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_ff          <= can_mode_pkg::INIT;
         busOffAtStart_ff <= 1'b0;
         wakeEvent_ff     <= 1'b0;
      end else begin
         wakeEvent_ff <= 1'b0;
         case (mode_ff)
            can_mode_pkg::RUN: begin
               if (init_request) begin
                  mode_ff <= can_mode_pkg::INIT; // RULE5
               end else if (sleep_request && busIdle) begin
                  mode_ff <= can_mode_pkg::SLEEP; // RULE2
               end
            end
            can_mode_pkg::SLEEP: begin
               if (init_request) begin
                  mode_ff <= can_mode_pkg::INIT;
               end else if (!sleep_request) begin
                  mode_ff <= can_mode_pkg::RUN; // RULE3
               end else if (wakeEn && activity) begin
                  mode_ff      <= can_mode_pkg::RUN; // RULE1
                  wakeEvent_ff <= 1'b1;
               end
            end
            can_mode_pkg::INIT: begin
               if (!init_request) begin
                  mode_ff          <= can_mode_pkg::RESYNC;
                  busOffAtStart_ff <= core.busOff;
               end
            end
            default: begin
               if (init_request) begin
                  mode_ff <= can_mode_pkg::INIT;
               end else if (resyncDone) begin
                  mode_ff <= can_mode_pkg::RUN;
               end
            end
         endcase
      end
   end
   ///////////////////////////////////////////////////////////////////////
   // Primary control: requests plus stop-in-wait option
   always_comb begin
      nxt_ctl0 = ctl0_ff;
      if (wr && paddr == can_mode_pkg::ADDR_CTL0) begin
         nxt_ctl0[can_mode_pkg::CTL0_WAKEEN] = wd[can_mode_pkg::CTL0_WAKEEN];
         nxt_ctl0[can_mode_pkg::CTL0_CSWAIT] = wd[can_mode_pkg::CTL0_CSWAIT];
         if (wd[can_mode_pkg::CTL0_SLEEP_REQUEST] || inSleep) begin
            nxt_ctl0[can_mode_pkg::CTL0_SLEEP_REQUEST] = wd[can_mode_pkg::CTL0_SLEEP_REQUEST]; // RULE4
         end
         if (wd[can_mode_pkg::CTL0_INIT_REQUEST] || inInit) begin
            nxt_ctl0[can_mode_pkg::CTL0_INIT_REQUEST] = wd[can_mode_pkg::CTL0_INIT_REQUEST]; // RULE12
         end
      end
      // Self wake clears the request; wins over a concurrent write
      if (mode_ff == can_mode_pkg::SLEEP && sleep_request && wakeEn && activity) begin
         nxt_ctl0[can_mode_pkg::CTL0_SLEEP_REQUEST] = 1'b0; // RULE3
      end
      if (nxt_ctl0[can_mode_pkg::CTL0_INIT_REQUEST] && !init_request) begin
         nxt_ctl0 = nxt_ctl0 & can_mode_pkg::KEEP_CTL0; // RULE6 RULE7
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctl0_ff <= can_mode_pkg::RST_CTL0;
      end else begin
         ctl0_ff <= nxt_ctl0;
      end
   end
   ///////////////////////////////////////////////////////////////////////
   // Secondary control: config bits locked outside init, acks from mode
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctl1_ff      <= can_mode_pkg::RST_CTL1;
         enWritten_ff <= 1'b0;
      end else begin
         if (wr && paddr == can_mode_pkg::ADDR_CTL1 && cfgOpen) begin // RULE8
            ctl1_ff[6:2] <= wd[6:2];
            ctl1_ff[3]   <= 1'b0;
            if (specialMode || !enWritten_ff) begin
               ctl1_ff[can_mode_pkg::CTL1_ENABLE] <=
                  wd[can_mode_pkg::CTL1_ENABLE]; // RULE16
               enWritten_ff <= !specialMode; // RULE16
            end
         end
         ctl1_ff[can_mode_pkg::CTL1_INIT_ACK] <=
            (mode_ff == can_mode_pkg::INIT); // RULE5 RULE23
         ctl1_ff[can_mode_pkg::CTL1_SLEEP_ACK] <=
            (mode_ff == can_mode_pkg::SLEEP) && sleep_request; // RULE3 RULE22 RULE23
      end
   end
   ///////////////////////////////////////////////////////////////////////
   // Flag and buffer registers reset on init entry; state fields kept
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rxFlag_ff <= can_mode_pkg::RST_RXFLAG;
         rxIe_ff   <= can_mode_pkg::RST_RXIE;
         txFlag_ff <= can_mode_pkg::RST_TXFLAG;
         txIe_ff   <= can_mode_pkg::RST_TXIE;
         txAbRq_ff <= can_mode_pkg::RST_TXABRQ;
         txAbAk_ff <= can_mode_pkg::RST_TXABAK;
         txBsel_ff <= can_mode_pkg::RST_TXBSEL;
      end else if (nxt_ctl0[can_mode_pkg::CTL0_INIT_REQUEST] && !init_request) begin
         rxFlag_ff <= can_mode_pkg::RST_RXFLAG; // RULE6
         rxIe_ff   <= (rxIe_ff & can_mode_pkg::KEEP_RX_STATE); // RULE7
         txFlag_ff <= can_mode_pkg::RST_TXFLAG;
         txIe_ff   <= (txIe_ff & can_mode_pkg::KEEP_TX_STATE); // RULE7
         txAbRq_ff <= can_mode_pkg::RST_TXABRQ;
         txAbAk_ff <= can_mode_pkg::RST_TXABAK;
         txBsel_ff <= can_mode_pkg::RST_TXBSEL;
      end else if (wr) begin
         if (paddr == can_mode_pkg::ADDR_RXFLAG) begin
            rxFlag_ff <= rxFlag_ff & ~wd;
         end else if (paddr == can_mode_pkg::ADDR_RXIE) begin
            rxIe_ff <= wd;
         end else if (paddr == can_mode_pkg::ADDR_TXFLAG) begin
            txFlag_ff <= wd;
         end else if (paddr == can_mode_pkg::ADDR_TXIE) begin
            txIe_ff <= wd;
         end else if (paddr == can_mode_pkg::ADDR_TXABRQ) begin
            txAbRq_ff <= wd;
         end else if (paddr == can_mode_pkg::ADDR_TXBSEL) begin
            txBsel_ff <= wd;
         end
      end
   end
   ///////////////////////////////////////////////////////////////////////
   // Timing and acceptance registers, writable only in init
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         btrA_ff   <= can_mode_pkg::RST_BTR;
         btrB_ff   <= can_mode_pkg::RST_BTR;
         accCtl_ff <= can_mode_pkg::RST_ACC;
      end else if (wr && cfgOpen) begin // RULE8
         if (paddr == can_mode_pkg::ADDR_BTRA) begin
            btrA_ff <= wd;
         end else if (paddr == can_mode_pkg::ADDR_BTRB) begin
            btrB_ff <= wd;
         end else if (paddr == can_mode_pkg::ADDR_ACCCTL) begin
            accCtl_ff <= wd;
         end
      end
   end

   for (genvar i = 0; i < can_mode_pkg::ACC_REGS; i++) begin : g_acc
      localparam logic [7:0] CODE_A = can_mode_pkg::ADDR_CODE0 + 8'(4 * i);
      localparam logic [7:0] MASK_A = can_mode_pkg::ADDR_MASK0 + 8'(4 * i);
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            code_ff[i] <= can_mode_pkg::RST_ACC;
            mask_ff[i] <= can_mode_pkg::RST_ACC;
         end else if (wr && cfgOpen) begin // RULE8
            if (paddr == CODE_A) begin
               code_ff[i] <= wd;
            end else if (paddr == MASK_A) begin
               mask_ff[i] <= wd;
            end
         end
      end
   end
   ///////////////////////////////////////////////////////////////////////
   // APB read path; zero-wait, unmapped reads zero with no error
   logic [7:0] rdv;
   logic [2:0] accIdx;
   assign accIdx = 3'((paddr - can_mode_pkg::ADDR_CODE0)
                      >> can_mode_pkg::ACC_IDX_LSB);
   always_comb begin
      rdv = 8'h00;
      if (paddr == can_mode_pkg::ADDR_CTL0) begin
         rdv = ctl0_ff;
      end else if (paddr == can_mode_pkg::ADDR_CTL1) begin
         rdv = ctl1_ff;
      end else if (paddr == can_mode_pkg::ADDR_RXFLAG) begin
         rdv = rxFlag_ff;
      end else if (paddr == can_mode_pkg::ADDR_RXIE) begin
         rdv = (rxIe_ff & ~can_mode_pkg::KEEP_RX_STATE)
             | (rxStateIn & can_mode_pkg::KEEP_RX_STATE);
      end else if (paddr == can_mode_pkg::ADDR_TXFLAG) begin
         rdv = txFlag_ff;
      end else if (paddr == can_mode_pkg::ADDR_TXIE) begin
         rdv = (txIe_ff & ~can_mode_pkg::KEEP_TX_STATE)
             | (txStateIn & can_mode_pkg::KEEP_TX_STATE);
      end else if (paddr == can_mode_pkg::ADDR_TXABRQ) begin
         rdv = txAbRq_ff;
      end else if (paddr == can_mode_pkg::ADDR_TXABAK) begin
         rdv = txAbAk_ff;
      end else if (paddr == can_mode_pkg::ADDR_TXBSEL) begin
         rdv = txBsel_ff;
      end else if (paddr == can_mode_pkg::ADDR_BTRA) begin
         rdv = btrA_ff;
      end else if (paddr == can_mode_pkg::ADDR_BTRB) begin
         rdv = btrB_ff;
      end else if (paddr == can_mode_pkg::ADDR_ACCCTL) begin
         rdv = accCtl_ff;
      end else if (paddr[1:0] == 2'h0 && paddr >= can_mode_pkg::ADDR_CODE0
                   && paddr < can_mode_pkg::ADDR_MASK0) begin
         rdv = code_ff[accIdx];
      end else if (paddr[1:0] == 2'h0 && paddr >= can_mode_pkg::ADDR_MASK0
                   && paddr < can_mode_pkg::ADDR_MASK0 + can_mode_pkg::ACC_SPAN) begin
         rdv = mask_ff[accIdx];
      end else if (paddr == can_mode_pkg::ADDR_STATUS) begin
         rdv = {5'h00, mode_ff};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= (psel && !penable) ? {24'h000000, rdv} : prdata;
      end
   end
   ///////////////////////////////////////////////////////////////////////
   // Pin and core outputs, all registered
   logic txForce;
   assign txForce = nxt_ctl0[can_mode_pkg::CTL0_INIT_REQUEST] // RULE13
      || mode_ff != can_mode_pkg::RUN
      || cpuStop || (cpuWait && ctl0_ff[can_mode_pkg::CTL0_CSWAIT]) // RULE15
      || ctl1_ff[can_mode_pkg::CTL1_LOOP] // RULE18
      || ctl1_ff[can_mode_pkg::CTL1_LISTEN] // RULE20
      || !ctl1_ff[can_mode_pkg::CTL1_ENABLE]; // RULE16

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busTxPin         <= 1'b1;
         coreRx           <= 1'b1;
         coreAbort        <= 1'b1;
         synced           <= 1'b0;
         useBusClock      <= 1'b0;
         moduleOn         <= 1'b0;
         loopMode         <= 1'b0;
         listenMode       <= 1'b0;
         ackEnable        <= 1'b0;
         errorFrameEnable <= 1'b0;
         errCountFreeze   <= 1'b0;
         wakeEvent        <= 1'b0;
      end else begin
         busTxPin    <= txForce ? 1'b1 : core.coreTx;
         coreRx      <= rxBit;
         coreAbort   <= init_request || mode_ff == can_mode_pkg::INIT; // RULE5
         synced      <= mode_ff == can_mode_pkg::RUN; // RULE5
         useBusClock <= ctl1_ff[can_mode_pkg::CTL1_CLKSEL]; // RULE17
         moduleOn    <= ctl1_ff[can_mode_pkg::CTL1_ENABLE]; // RULE16
         loopMode    <= ctl1_ff[can_mode_pkg::CTL1_LOOP]; // RULE19
         listenMode  <= ctl1_ff[can_mode_pkg::CTL1_LISTEN];
         // Ack slot ignored in loopback, never sent in listen-only
         ackEnable <= !ctl1_ff[can_mode_pkg::CTL1_LISTEN]
                      && !ctl1_ff[can_mode_pkg::CTL1_LOOP]; // RULE19 RULE20
         errorFrameEnable <= !ctl1_ff[can_mode_pkg::CTL1_LISTEN]; // RULE20
         // Error counters live in the core; init never touches them
         errCountFreeze <= ctl1_ff[can_mode_pkg::CTL1_LISTEN]; // RULE20 RULE9
         wakeEvent      <= wakeEvent_ff;
      end
   end
endmodule : can_mode_control
